// File: include/emps_cfg.svh
// Purpose: pin sharing constants
// Assumes: included by the pin mux
// Notes:   positions are pin/core bit indices
`ifndef EMPS_CFG_SVH
`define EMPS_CFG_SVH
// sdram row/column field on address pins
`define EMPS_MA_HI      10
`define EMPS_MA_LO      1
// linear bank address: pins and core bits
`define EMPS_BA_HI      15
`define EMPS_BA_LO      11
`define EMPS_BA_CORE_HI 25
`define EMPS_BA_CORE_LO 21
// interleaved bank address: pins and core bits
`define EMPS_IBA_HI     19
`define EMPS_IBA_LO     16
`define EMPS_IBA_CORE_HI 12
`define EMPS_IBA_CORE_LO 9
// shared chip select pins
`define EMPS_CS_GEN0    2
`define EMPS_CS_GEN1    3
// select value out of reset: sdram selects
`define EMPS_SEL_RST    1'h0
// boot pattern for boot from sdram select 1
`define EMPS_BOOT_FLASH 4'h4
// boot pins settle wait, in clk cycles
`define EMPS_BOOT_WAIT  2'h3
// long first access after a restart
`define EMPS_LONG_CYC   3'h4
`endif

// File: include/emps_pkg.sv
// Purpose: types for the pin mux
// Assumes: nothing
// Notes:   none
package emps_pkg;
  // external bus unit request
  typedef struct packed {
    logic        active;
    logic        read;
    logic        burst;
    logic [3:0]  byte_en;
    logic [5:0]  cs_n;
    logic [24:0] addr;
  } emps_eiu_req_type;
  // sdram controller request
  typedef struct packed {
    logic        cycle;
    logic        interleave;
    logic [1:0]  cs_n;
    logic [9:0]  row_col;
    logic [25:0] core_addr;
  } emps_sd_req_type;
  // burst sequencing states
  typedef enum logic [2:0] {
    EMPS_IDLE  = 3'h1,
    EMPS_BURST = 3'h2,
    EMPS_LONG  = 3'h4
  } emps_burst_state_type;
endpackage

// File: src/emps_pin_mux.sv
// Purpose: external memory pin sharing
// Assumes: controllers run on link_clk
// Notes:   clk side holds boot capture
//
// Function
// R1: drive four low-true byte strobes, msb lane first.
// R2: drive low-true output enable during reads.
// R3: cs 3:2 shared with sdram selects; sdram selects out of reset.
// R4: end-burst input ends burst, restarts with long first access.
// R5: memory latches start address while load-address is low.
// R6: supply burst clock while bursting; held low during long first access.
// R7: read/write line high on read, low on write.
// R8: linear mode: core 25:21 on address pins 15:11.
// R9: interleaved mode: core 12:9 on address pins 19:16.
// R10: sdram row/column on address pins 10:1 in sdram cycles.
// R11: sdram select 1 serves as flash boot select.
// R12: boot mode taken from boot pins at reset.
// R13: outside sdram cycles, address pins carry bus address.
`timescale 1ns/100ps
`include "emps_cfg.svh"
`default_nettype none
module emps_pin_mux (
  // system side
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic [3:0]                boot_pins,
  input  wire logic                      function_mux_control,
  output logic [3:0]                     boot_mode_r,
  output logic                           boot_valid_r,
  // controller side, link clock
  input  wire logic                      link_clk,
  input  wire emps_pkg::emps_eiu_req_type eiu_req,
  input  wire emps_pkg::emps_sd_req_type sd_req,
  output logic                           burst_restart_r,
  // memory pins
  output logic [24:0]                    addr_pin_r,
  output logic [5:0]                     cs_pin_n_r,
  output logic                           byte_lane_strobe_msb_n_r,
  output logic                           byte_lane_strobe_upper_mid_n_r,
  output logic                           byte_lane_strobe_lower_mid_n_r,
  output logic                           byte_lane_strobe_lsb_n_r,
  output logic                           oe_n_r,
  output logic                           rw_r,
  output logic                           bclk_r,
  output logic                           load_burst_address_n_r,
  input  wire logic                      end_current_burst_n
);

  logic [3:0]  boot_s1_r;
  logic [3:0]  boot_s2_r;
  logic [1:0]  boot_wait_r;
  logic        boot_flash_r;
  logic        fmc_s1_r;
  logic        fmc_s2_r;
  logic        bflash_s1_r;
  logic        bflash_s2_r;
  logic        ecb_s1_r;
  logic        ecb_s2_r;
  logic        ecb_s3_r;
  logic        restart_req;
  logic [2:0]  long_cnt_r;
  logic [24:0] addr_nxt;
  logic [3:0]  lane_n_nxt;
  logic [5:0]  cs_nxt;
  logic        bursting;
  emps_pkg::emps_burst_state_type state_r;
  emps_pkg::emps_burst_state_type state_nxt;

  // boot pins come from the board: two stages first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_s1_r <= 4'h0;
      boot_s2_r <= 4'h0;
    end else begin
      boot_s1_r <= boot_pins;
      boot_s2_r <= boot_s1_r;
    end
  end

  // capture once after release, never on the fly
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_wait_r  <= 2'h0;
      boot_valid_r <= 1'h0;
      boot_mode_r  <= 4'h0;
      boot_flash_r <= 1'h0;
    end else if (!boot_valid_r) begin
      if (boot_wait_r == `EMPS_BOOT_WAIT) begin
        boot_valid_r <= 1'h1; // R12
        boot_mode_r  <= boot_s2_r; // R12
        boot_flash_r <= (boot_s2_r == `EMPS_BOOT_FLASH); // R11
      end else begin
        boot_wait_r <= boot_wait_r + 2'h1;
      end
    end
  end

  // quasi-static levels into the link domain
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      fmc_s1_r    <= `EMPS_SEL_RST;
      fmc_s2_r    <= `EMPS_SEL_RST;
      bflash_s1_r <= 1'h0;
      bflash_s2_r <= 1'h0;
    end else begin
      fmc_s1_r    <= function_mux_control;
      fmc_s2_r    <= fmc_s1_r;
      bflash_s1_r <= boot_flash_r;
      bflash_s2_r <= bflash_s1_r;
    end
  end

  // end-burst pin: sync, then edge on stages two/three
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      ecb_s1_r <= 1'h1;
      ecb_s2_r <= 1'h1;
      ecb_s3_r <= 1'h1;
    end else begin
      ecb_s1_r <= end_current_burst_n;
      ecb_s2_r <= ecb_s1_r;
      ecb_s3_r <= ecb_s2_r;
    end
  end

  assign restart_req = ecb_s3_r & !ecb_s2_r;
  assign bursting = eiu_req.active & eiu_req.burst;

  // address pin sharing
  always_comb begin
    addr_nxt = eiu_req.addr; // R13
    if (sd_req.cycle) begin
      addr_nxt[`EMPS_MA_HI:`EMPS_MA_LO] = sd_req.row_col; // R10
      if (sd_req.interleave) begin
        addr_nxt[`EMPS_IBA_HI:`EMPS_IBA_LO] =
          sd_req.core_addr[`EMPS_IBA_CORE_HI:`EMPS_IBA_CORE_LO]; // R9
      end else begin
        addr_nxt[`EMPS_BA_HI:`EMPS_BA_LO] =
          sd_req.core_addr[`EMPS_BA_CORE_HI:`EMPS_BA_CORE_LO]; // R8
      end
    end
  end

  // chip select sharing; flash boot pins sdram select 1
  always_comb begin
    cs_nxt = eiu_req.cs_n;
    if (!fmc_s2_r) begin
      cs_nxt[`EMPS_CS_GEN0] = sd_req.cs_n[0]; // R3
    end
    if (!fmc_s2_r || bflash_s2_r) begin
      cs_nxt[`EMPS_CS_GEN1] = sd_req.cs_n[1]; // R3 R11
    end
  end

  // one strobe per lane; byte_en[3] is the msb lane
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign lane_n_nxt[gi] = !(eiu_req.active & eiu_req.byte_en[gi]);
    end
  endgenerate

  // pin registers: outputs straight from flops
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      addr_pin_r <= 25'h0;
      cs_pin_n_r <= 6'h3f;
      byte_lane_strobe_msb_n_r       <= 1'h1;
      byte_lane_strobe_upper_mid_n_r <= 1'h1;
      byte_lane_strobe_lower_mid_n_r <= 1'h1;
      byte_lane_strobe_lsb_n_r       <= 1'h1;
      oe_n_r <= 1'h1;
      rw_r   <= 1'h1;
    end else begin
      addr_pin_r <= addr_nxt;
      cs_pin_n_r <= cs_nxt;
      byte_lane_strobe_msb_n_r       <= lane_n_nxt[3]; // R1
      byte_lane_strobe_upper_mid_n_r <= lane_n_nxt[2]; // R1
      byte_lane_strobe_lower_mid_n_r <= lane_n_nxt[1]; // R1
      byte_lane_strobe_lsb_n_r       <= lane_n_nxt[0]; // R1
      oe_n_r <= !(eiu_req.active & eiu_req.read); // R2
      rw_r   <= !eiu_req.active | eiu_req.read; // R7
    end
  end

  // burst sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      emps_pkg::EMPS_IDLE: begin
        if (bursting) state_nxt = emps_pkg::EMPS_BURST;
      end
      emps_pkg::EMPS_BURST: begin
        if (!bursting) state_nxt = emps_pkg::EMPS_IDLE;
        else if (restart_req) state_nxt = emps_pkg::EMPS_LONG; // R4
      end
      emps_pkg::EMPS_LONG: begin
        if (!bursting) state_nxt = emps_pkg::EMPS_IDLE;
        else if (long_cnt_r == 3'h1) state_nxt = emps_pkg::EMPS_BURST;
      end
      default: state_nxt = emps_pkg::EMPS_IDLE;
    endcase
  end

  // state and long first access count
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      state_r    <= emps_pkg::EMPS_IDLE;
      long_cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == emps_pkg::EMPS_LONG && state_r != emps_pkg::EMPS_LONG)
        long_cnt_r <= `EMPS_LONG_CYC; // R4
      else if (long_cnt_r != 3'h0)
        long_cnt_r <= long_cnt_r - 3'h1;
    end
  end

  // burst clock, address load and restart notice
  // clock halves link rate so memory sees stable edges
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      bclk_r <= 1'h0;
      load_burst_address_n_r <= 1'h1;
      burst_restart_r <= 1'h0;
    end else begin
      bclk_r <= (state_nxt == emps_pkg::EMPS_BURST) & !bclk_r; // R6
      load_burst_address_n_r <= !(state_nxt == emps_pkg::EMPS_BURST &&
                                  state_r != emps_pkg::EMPS_BURST); // R5
      burst_restart_r <= (state_r == emps_pkg::EMPS_BURST) &
                         bursting & restart_req; // R4
    end
  end

  // checks on the pin side
  AST_STROBE_MSB: assert property (@(posedge link_clk) disable iff (!nrst) // R1
    eiu_req.active & eiu_req.byte_en[3] |=> !byte_lane_strobe_msb_n_r)
    else $error("msb strobe not asserted");
  AST_STROBE_LSB: assert property (@(posedge link_clk) disable iff (!nrst) // R1
    !eiu_req.active |=> byte_lane_strobe_lsb_n_r)
    else $error("lsb strobe asserted while idle");
  AST_OE_READ: assert property (@(posedge link_clk) disable iff (!nrst) // R2
    eiu_req.active & eiu_req.read |=> !oe_n_r && rw_r)
    else $error("read without output enable");
  AST_CS_DEFAULT: assert property (@(posedge link_clk) disable iff (!nrst) // R3
    !fmc_s2_r |=> cs_pin_n_r[`EMPS_CS_GEN0] == $past(sd_req.cs_n[0]))
    else $error("sdram select 0 not on shared pin");
  AST_CS_GEN: assert property (@(posedge link_clk) disable iff (!nrst) // R3
    fmc_s2_r |=> cs_pin_n_r[`EMPS_CS_GEN0] == $past(eiu_req.cs_n[`EMPS_CS_GEN0]))
    else $error("general select 2 not on shared pin");
  AST_RESTART: assert property (@(posedge link_clk) disable iff (!nrst) // R4
    state_r == emps_pkg::EMPS_BURST && bursting && restart_req
    |=> burst_restart_r && state_r == emps_pkg::EMPS_LONG)
    else $error("end-burst not honoured");
  AST_RESTART_ONE: assert property (@(posedge link_clk) disable iff (!nrst) // R4
    burst_restart_r |=> !burst_restart_r)
    else $error("restart notice longer than one cycle");
  AST_LONG_LEN: assert property (@(posedge link_clk) disable iff (!nrst) // R4
    $rose(state_r == emps_pkg::EMPS_LONG) && bursting
    |-> (state_r == emps_pkg::EMPS_LONG)[*4])
    else $error("long first access too short");
  AST_LOAD_ADDR: assert property (@(posedge link_clk) disable iff (!nrst) // R5
    !load_burst_address_n_r |-> state_r == emps_pkg::EMPS_BURST)
    else $error("address load outside burst start");
  AST_BCLK_IDLE: assert property (@(posedge link_clk) disable iff (!nrst) // R6
    bclk_r |-> state_r == emps_pkg::EMPS_BURST)
    else $error("burst clock outside burst");
  AST_RW_WRITE: assert property (@(posedge link_clk) disable iff (!nrst) // R7
    eiu_req.active & !eiu_req.read |=> !rw_r && oe_n_r)
    else $error("write not driven low");
  AST_BANK_LIN: assert property (@(posedge link_clk) disable iff (!nrst) // R8
    sd_req.cycle & !sd_req.interleave |=> addr_pin_r[`EMPS_BA_HI:`EMPS_BA_LO]
    == $past(sd_req.core_addr[`EMPS_BA_CORE_HI:`EMPS_BA_CORE_LO]))
    else $error("linear bank address wrong");
  AST_BANK_INT: assert property (@(posedge link_clk) disable iff (!nrst) // R9
    sd_req.cycle & sd_req.interleave |=> addr_pin_r[`EMPS_IBA_HI:`EMPS_IBA_LO]
    == $past(sd_req.core_addr[`EMPS_IBA_CORE_HI:`EMPS_IBA_CORE_LO]))
    else $error("interleaved bank address wrong");
  AST_ROWCOL: assert property (@(posedge link_clk) disable iff (!nrst) // R10
    sd_req.cycle |=> addr_pin_r[`EMPS_MA_HI:`EMPS_MA_LO] == $past(sd_req.row_col))
    else $error("row/column address wrong");
  AST_BOOT_CS: assert property (@(posedge link_clk) disable iff (!nrst) // R11
    bflash_s2_r |=> cs_pin_n_r[`EMPS_CS_GEN1] == $past(sd_req.cs_n[1]))
    else $error("boot select not on sdram select 1");
  AST_BOOT_HOLD: assert property (@(posedge clk) disable iff (!nrst) // R12
    boot_valid_r |=> boot_valid_r && $stable(boot_mode_r))
    else $error("boot mode changed after capture");
  AST_PLAIN_ADDR: assert property (@(posedge link_clk) disable iff (!nrst) // R13
    !sd_req.cycle |=> addr_pin_r == $past(eiu_req.addr))
    else $error("bus address not on pins");

  // main scenarios
  COV_BURST: cover property (@(posedge link_clk) disable iff (!nrst)
    state_r == emps_pkg::EMPS_IDLE ##1 state_r == emps_pkg::EMPS_BURST);
  COV_RESTART: cover property (@(posedge link_clk) disable iff (!nrst)
    burst_restart_r ##5 state_r == emps_pkg::EMPS_BURST);
  COV_SD_INT: cover property (@(posedge link_clk) disable iff (!nrst)
    sd_req.cycle & sd_req.interleave);
  COV_BOOT: cover property (@(posedge clk) disable iff (!nrst)
    $rose(boot_valid_r) && boot_flash_r);

endmodule // emps_pin_mux
`default_nettype wire

// File: sim/emps_mem_model.sv
// Purpose: burst memory model on the far side of the pins
// Assumes: pins registered on link_clk
// Notes:   end-burst line idles high, as if pulled up
`timescale 1ns/100ps
`default_nettype none
module emps_mem_model (
  // memory pins
  input  wire logic        link_clk,
  input  wire logic [24:0] addr_pin,
  input  wire logic        load_burst_address_n,
  output logic             end_current_burst_n,
  // bench control and view
  input  wire logic        end_req,
  output logic [24:0]      start_addr_r
);
  // latch start address while load is low
  always @(posedge link_clk) begin
    if (!load_burst_address_n) start_addr_r <= addr_pin;
  end
  // end-burst held low two link cycles, only when the bench asks;
  // one process owns the line so it keeps a single driver
  initial begin
    end_current_burst_n = 1'b1;
    forever begin
      @(posedge end_req);
      @(negedge link_clk) end_current_burst_n = 1'b0;
      repeat (2) @(negedge link_clk);
      end_current_burst_n = 1'b1;
    end
  end
endmodule // emps_mem_model

// File: sim/emps_tb.sv
// Purpose: self-checking bench for the pin mux
// Assumes: pins answer one link cycle after a request
// Notes:   notes queued by the driver, compared by the monitor
`timescale 1ns/100ps
`include "emps_cfg.svh"
`default_nettype none
module external_memory_pin_sharing_tb_top;
  logic clk = 0, link_clk = 0, nrst = 0, fmc = 0, end_req = 0;
  logic [3:0] boot_pins = '0, boot_mode_r;
  emps_pkg::emps_eiu_req_type eiu = '0;
  emps_pkg::emps_sd_req_type  sd = '0;
  logic boot_valid_r, burst_restart_r, oe_n_r, rw_r, bclk_r, lba_n, ecb_n;
  logic s0, s1, s2, s3;
  logic [24:0] addr_pin_r;
  logic [5:0]  cs_pin_n_r;
  logic [24:0] mem_start;
  logic [3:0]  boot_ref = '0;
  int errors = 0, total_checks = 0;
  logic [31:0] seed = 32'h33b8_007c;
  logic [36:0] note_q[$];
  event seen;
  // clocks; link phase offset so edges never line up
  always #2.5 clk = ~clk;
  initial begin
    #13.3;
    forever #40 link_clk = ~link_clk;
  end
  emps_pin_mux u_dut (.clk(clk), .nrst(nrst), .boot_pins(boot_pins),
    .function_mux_control(fmc), .boot_mode_r(boot_mode_r), .boot_valid_r(boot_valid_r),
    .link_clk(link_clk), .eiu_req(eiu), .sd_req(sd), .burst_restart_r(burst_restart_r),
    .addr_pin_r(addr_pin_r), .cs_pin_n_r(cs_pin_n_r), .byte_lane_strobe_msb_n_r(s3),
    .byte_lane_strobe_upper_mid_n_r(s2), .byte_lane_strobe_lower_mid_n_r(s1),
    .byte_lane_strobe_lsb_n_r(s0), .oe_n_r(oe_n_r), .rw_r(rw_r), .bclk_r(bclk_r),
    .load_burst_address_n_r(lba_n), .end_current_burst_n(ecb_n));
  emps_mem_model u_mem (.link_clk(link_clk), .addr_pin(addr_pin_r),
    .load_burst_address_n(lba_n), .end_current_burst_n(ecb_n), .end_req(end_req),
    .start_addr_r(mem_start));
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // expected pins from the request in flight
  function logic [36:0] expect_pins();
    logic [24:0] a;
    logic [5:0]  c;
    a = eiu.addr;
    c = eiu.cs_n;
    if (!fmc) c[2] = sd.cs_n[0];
    if (!fmc || boot_ref == `EMPS_BOOT_FLASH) c[3] = sd.cs_n[1];
    if (sd.cycle) begin
      a[10:1] = sd.row_col;
      if (sd.interleave) a[19:16] = sd.core_addr[12:9];
      else a[15:11] = sd.core_addr[25:21];
    end
    return {a, c, ~(eiu.byte_en & {4{eiu.active}}), ~(eiu.active & eiu.read),
            ~(eiu.active & ~eiu.read)};
  endfunction
  task check(input logic [36:0] got_v, input logic [36:0] exp_v);
    total_checks++;
    if (got_v !== exp_v) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task end_sim();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // monitor: oldest note against the pins
  always @(seen) begin
    check({addr_pin_r, cs_pin_n_r, s3, s2, s1, s0, oe_n_r, rw_r},
          note_q.pop_front());
  end
  task do_reset(input logic [3:0] b);
    int n;
    nrst = 1'b0;
    boot_pins = b;
    boot_ref = b;
    eiu = '0;
    sd = '0;
    repeat (2) @(negedge link_clk);
    nrst = 1'b1;
    n = 0;
    while (boot_valid_r !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      errors++;
      end_sim();
    end else begin
      check({33'h0, boot_mode_r}, {33'h0, b});
      // board may reuse the straps once captured
      @(negedge clk) boot_pins = ~b;
      $display("boot test done pattern=%h", b);
    end
  endtask
  // random request each link cycle, back to back
  task cyc();
    logic [31:0] r0;
    emps_pkg::emps_eiu_req_type e;
    seed = xs(seed);
    r0 = seed;
    seed = xs(seed);
    e = {r0[5:0], seed};
    e.burst = 1'b0; // bursts belong to burst_test
    eiu = e;
    seed = xs(seed);
    sd = {r0[13:6], seed};
    note_q.push_back(expect_pins());
    @(negedge link_clk);
    -> seen;
  endtask
  task run_mux();
    for (int f = 0; f < 2; f++) begin
      @(negedge clk) fmc = f[0];
      // selects need two link flops plus skew to settle
      repeat (4) @(negedge link_clk);
      repeat (24) cyc();
    end
    check({33'h0, boot_mode_r}, {33'h0, boot_ref});
    $display("mux test done boot=%h", boot_ref);
  endtask
  task burst_test();
    int n;
    @(negedge link_clk);
    sd = '0;
    eiu = '{active: 1'b1, read: 1'b1, burst: 1'b1, byte_en: 4'hf, cs_n: 6'h3e,
            addr: 25'h000_0123};
    @(negedge link_clk) check({35'h0, lba_n, bclk_r}, 37'h1);
    @(negedge link_clk) check({35'h0, lba_n, bclk_r}, 37'h2);
    check({12'h0, mem_start}, {12'h0, 25'h000_0123});
    end_req = 1'b1;
    n = 0;
    while (burst_restart_r !== 1'b1 && n < 10) begin
      @(negedge link_clk);
      n++;
    end
    check({36'h0, n < 10}, 37'h1);
    n = 0;
    while (lba_n !== 1'b0 && n < 8) begin
      @(negedge link_clk);
      n++;
    end
    check({32'h0, n[4:0]}, {34'h0, `EMPS_LONG_CYC});
    check({35'h0, lba_n, bclk_r}, 37'h1);
    @(negedge link_clk) check({35'h0, lba_n, bclk_r}, 37'h2);
    eiu = '0;
    end_req = 1'b0;
    @(negedge link_clk);
    $display("burst test done");
  endtask
  initial begin
    do_reset(`EMPS_BOOT_FLASH);
    run_mux();
    burst_test();
    do_reset(4'h9);
    run_mux();
    end_sim();
  end
endmodule // external_memory_pin_sharing_tb_top
`default_nettype wire
